// file: hdl/eep_host_end.sv
/*
  Master end of the two-wire EEPROM link: makes SCL by dividing i_clk,
  issues byte write, page write, current, random and sequential reads.
  Assumes the user holds i_wdata for each data byte until it is taken.
*/
`timescale 1ns/10ps
module eep_host_end (
  eep_link_if.host                     link,
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_cmd_valid,
  input  wire eep_pkg::eep_op_t        i_cmd_op,
  input  wire logic [eep_pkg::ADDR_W-1:0] i_cmd_addr,
  input  wire logic [eep_pkg::LEN_W-1:0]  i_cmd_len,
  input  wire logic [7:0]              i_wdata,
  input  wire logic                    i_wp,
  output logic                         o_cmd_ready,
  output logic                         o_wdata_take,
  output logic [7:0]                   o_rdata,
  output logic                         o_rdata_valid,
  output logic                         o_nack
);
  import eep_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_START = 2'b01, H_BIT = 2'b11, H_STOP = 2'b10
  } eep_hst_t;

  typedef struct packed {
    eep_hst_t          st;
    logic [1:0]        q;
    logic [QCNT_W-1:0] qcnt;
    logic [3:0]        bitcnt;
    logic [7:0]        shreg;
    logic [2:0]        step;
    eep_op_t           op;
    logic [LEN_W-1:0]  len;
    logic [ADDR_W-1:0] addr;
    logic              ackbit;
    logic              scl;
    logic              sda_oe;
    logic              wp;
    logic [1:0]        sdas;
    logic [7:0]        rdata;
    logic              rdata_v;
    logic              wtake;
    logic              nack;
    logic              ready;
  } eep_host_t;

  eep_host_t s_ff;
  eep_host_t nxt_s;
  logic      tick;
  logic      rx;

  function automatic logic [7:0] tx_byte(input logic [2:0] step,
      input logic [ADDR_W-1:0] addr, input logic [7:0] wd);
    unique case (step)
      HS_DEV:  return {TYPE_ID, SUB_ADDR, RW_WRITE};
      HS_RDEV: return {TYPE_ID, SUB_ADDR, RW_READ};
      HS_AHI:  return {4'h0, addr[ADDR_W-1:8]};
      HS_ALO:  return addr[7:0];
      default: return wd;
    endcase
  endfunction

  // Enter a byte: load it and report a taken data byte
  function automatic eep_host_t go_byte(input eep_host_t h,
      input logic [2:0] step, input logic [7:0] wd);
    eep_host_t r;
    r        = h;
    r.st     = H_BIT;
    r.step   = step;
    r.bitcnt = '0;
    r.shreg  = tx_byte(step, h.addr, wd);
    r.wtake  = (step == HS_WDAT);
    return r;
  endfunction

  assign tick = (s_ff.qcnt == QCNT_W'(QTR_CYC - 1));
  assign rx   = (s_ff.step == HS_RDAT);

  always_comb begin
    nxt_s         = s_ff;
    nxt_s.rdata_v = 1'b0;
    nxt_s.wtake   = 1'b0;
    nxt_s.nack    = 1'b0;
    nxt_s.wp      = i_wp;
    nxt_s.sdas    = {s_ff.sdas[0], link.sda};
    nxt_s.qcnt    = (tick || s_ff.st == H_IDLE) ? '0 : s_ff.qcnt + 8'h1;
    if (tick) nxt_s.q = s_ff.q + 2'h1;
    unique case (s_ff.st)
      H_IDLE: begin
        nxt_s.q = '0;
        if (i_cmd_valid) begin
          nxt_s.ready = 1'b0;
          nxt_s.st    = H_START;
          nxt_s.op    = i_cmd_op;
          nxt_s.addr  = i_cmd_addr;
          nxt_s.len   = i_cmd_len;
          nxt_s.step  = (i_cmd_op == OP_CUR) ? HS_RDEV : HS_DEV;
        end
      end
      H_START: if (tick) begin
        unique case (s_ff.q)
          2'h0: nxt_s.sda_oe = 1'b0;
          2'h1: nxt_s.scl    = 1'b1;
          2'h2: nxt_s.sda_oe = 1'b1;
          2'h3: begin
            nxt_s.scl = 1'b0;
            nxt_s     = go_byte(nxt_s, s_ff.step, i_wdata);
          end
        endcase
      end
      H_BIT: if (tick) begin
        unique case (s_ff.q)
          2'h0: begin
            if (s_ff.bitcnt == ACK_BIT)
              nxt_s.sda_oe = rx && (s_ff.len != 13'h1);
            else
              nxt_s.sda_oe = !rx && !s_ff.shreg[7];
          end
          2'h1: nxt_s.scl = 1'b1;
          2'h2: begin
            if (s_ff.bitcnt == ACK_BIT) nxt_s.ackbit = s_ff.sdas[1];
            else if (rx) nxt_s.shreg = {s_ff.shreg[6:0], s_ff.sdas[1]};
          end
          2'h3: begin
            nxt_s.scl    = 1'b0;
            nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
            if (!rx && s_ff.bitcnt != ACK_BIT)
              nxt_s.shreg = {s_ff.shreg[6:0], 1'b0};
            if (s_ff.bitcnt == ACK_BIT) begin
              nxt_s.bitcnt = '0;
              if (rx) begin
                nxt_s.rdata   = s_ff.shreg;
                nxt_s.rdata_v = 1'b1;
                nxt_s.len     = s_ff.len - 13'h1;
                if (s_ff.len == 13'h1) nxt_s.st = H_STOP;
              end else if (s_ff.ackbit) begin
                nxt_s.nack = 1'b1;
                nxt_s.st   = H_STOP;
              end else begin
                unique case (s_ff.step)
                  HS_DEV:  nxt_s = go_byte(nxt_s, HS_AHI, i_wdata);
                  HS_AHI:  nxt_s = go_byte(nxt_s, HS_ALO, i_wdata);
                  HS_ALO: begin
                    if (s_ff.op == OP_RAND) begin
                      nxt_s.st   = H_START;
                      nxt_s.step = HS_RDEV;
                    end else if (s_ff.len == '0) begin
                      nxt_s.st = H_STOP;
                    end else begin
                      nxt_s = go_byte(nxt_s, HS_WDAT, i_wdata);
                    end
                  end
                  HS_WDAT: begin
                    nxt_s.len = s_ff.len - 13'h1;
                    if (s_ff.len == 13'h1) nxt_s.st = H_STOP;
                    else nxt_s = go_byte(nxt_s, HS_WDAT, i_wdata);
                  end
                  default: nxt_s = go_byte(nxt_s, HS_RDAT, i_wdata);
                endcase
              end
            end
          end
        endcase
      end
      H_STOP: if (tick) begin
        unique case (s_ff.q)
          2'h0: nxt_s.sda_oe = 1'b1;
          2'h1: nxt_s.scl    = 1'b1;
          2'h2: nxt_s.sda_oe = 1'b0;
          2'h3: begin
            nxt_s.st    = H_IDLE;
            nxt_s.ready = 1'b1;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_ff       <= '0;
      s_ff.scl   <= 1'b1;
      s_ff.ready <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.scl      = s_ff.scl;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = s_ff.sda_oe;
  assign link.wp       = s_ff.wp;
  assign o_cmd_ready   = s_ff.ready;
  assign o_wdata_take  = s_ff.wtake;
  assign o_rdata       = s_ff.rdata;
  assign o_rdata_valid = s_ff.rdata_v;
  assign o_nack        = s_ff.nack;
endmodule  // eep_host_end

// file: hdl/eep_pkg.sv
/*
  Shared constants and types of the two-wire serial EEPROM link.
  Assumes a 50 MHz system clock on both ends.
*/
package eep_pkg;
  localparam int ADDR_W = 12;
  localparam int OFS_W  = 5;
  localparam int PAGE_N = 32;
  localparam int WORDS  = 4096;
  localparam int LEN_W  = 13;
  localparam int TMR_W  = 20;
  localparam int QCNT_W = 8;
  // Device type code: value is arbitrary
  localparam logic [3:0] TYPE_ID  = 4'h6;
  localparam logic [2:0] SUB_ADDR = 3'h0;
  localparam logic       RW_READ  = 1'b1;
  localparam logic       RW_WRITE = 1'b0;
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [7:0] ERASED   = 8'hFF;
  localparam logic [1:0] BI_DEV   = 2'h0;
  localparam logic [1:0] BI_AHI   = 2'h1;
  localparam logic [1:0] BI_ALO   = 2'h2;
  localparam logic [1:0] BI_DATA  = 2'h3;
  localparam logic [2:0] HS_DEV   = 3'h0;
  localparam logic [2:0] HS_AHI   = 3'h1;
  localparam logic [2:0] HS_ALO   = 3'h2;
  localparam logic [2:0] HS_WDAT  = 3'h3;
  localparam logic [2:0] HS_RDEV  = 3'h4;
  localparam logic [2:0] HS_RDAT  = 3'h5;
  localparam int CLK_MHZ  = 50;
  localparam int TWR_US   = 5000;
  localparam int TWR_CYC  = TWR_US * CLK_MHZ;
  localparam int SCL_KHZ  = 100;
  localparam int QTR_CYC  =
    (CLK_MHZ * 1000 + SCL_KHZ * 4 - 1) / (SCL_KHZ * 4);
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0, OP_CUR = 2'h1, OP_RAND = 2'h2
  } eep_op_t;
  typedef logic [8*PAGE_N-1:0] eep_page_t;
endpackage

// file: hdl/eep_link_if.sv
/*
  Two-wire link between bus master and EEPROM device.
  SDA is open drain: a party pulls low while its enable is high.
*/
`timescale 1ns/10ps
interface eep_link_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic wp;
  logic sda;
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport host (output scl, output sda_m_o, output sda_m_oe,
                output wp, input sda);
  modport dev (input scl, input sda, input wp,
               output sda_s_o, output sda_s_oe);
endinterface

// file: hdl/eep_wcycle.sv
/*
  Self-timed write cycle and the memory array, on the system clock.
  Assumes page data, mask and page number are steady once the stop
  has been seen, since the link clock stands still after it.
*/
`timescale 1ns/10ps
module eep_wcycle #(
  parameter int TWR_CYC = eep_pkg::TWR_CYC
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_sys_rst,
  input  wire logic                              i_stop_tgl,
  input  wire logic                              i_wr_ok,
  input  wire logic                              i_wp,
  input  wire logic [eep_pkg::ADDR_W-eep_pkg::OFS_W-1:0] i_page,
  input  wire logic [eep_pkg::PAGE_N-1:0]        i_mask,
  input  wire eep_pkg::eep_page_t                i_pbuf,
  input  wire logic [eep_pkg::ADDR_W-1:0]        i_rd_addr,
  output logic      [7:0]                        o_rd_data,
  output logic                                   o_busy,
  output logic                                   o_abort
);
  import eep_pkg::*;

  typedef struct packed {
    logic [2:0]              stp;
    logic [1:0]              wps;
    logic [1:0]              oks;
    logic                    busy;
    logic                    wdone;
    logic                    abort;
    logic [OFS_W-1:0]        idx;
    logic [TMR_W-1:0]        tmr;
    logic [ADDR_W-OFS_W-1:0] page;
    logic [PAGE_N-1:0]       mask;
    eep_page_t               pbuf;
  } eep_wc_t;

  eep_wc_t    s_ff;
  eep_wc_t    nxt_s;
  logic [7:0] mem [WORDS];
  logic       wr_en;

  always_comb begin
    nxt_s       = s_ff;
    nxt_s.stp   = {s_ff.stp[1:0], i_stop_tgl};
    nxt_s.wps   = {s_ff.wps[0], i_wp};
    nxt_s.oks   = {s_ff.oks[0], i_wr_ok};
    nxt_s.abort = 1'b0;
    if (!s_ff.busy) begin
      if ((s_ff.stp[2] ^ s_ff.stp[1]) && s_ff.oks[1] && !s_ff.wps[1]) begin
        nxt_s.busy  = 1'b1;
        nxt_s.wdone = 1'b0;
        nxt_s.idx   = '0;
        nxt_s.tmr   = '0;
        nxt_s.page  = i_page;
        nxt_s.mask  = i_mask;
        nxt_s.pbuf  = i_pbuf;
      end
    end else if (s_ff.wps[1]) begin
      nxt_s.busy  = 1'b0;
      nxt_s.abort = 1'b1;
    end else begin
      nxt_s.idx = s_ff.idx + 5'h1;
      nxt_s.tmr = s_ff.tmr + 20'h1;
      if (s_ff.idx == 5'h1F) nxt_s.wdone = 1'b1;
      if (int'(s_ff.tmr) >= TWR_CYC - 1) nxt_s.busy = 1'b0;
    end
  end

  assign wr_en = s_ff.busy && !s_ff.wps[1] && !s_ff.wdone
                 && s_ff.mask[s_ff.idx];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_ff <= '0;
      for (int i = 0; i < WORDS; i++) mem[i] <= ERASED;
    end else begin
      s_ff <= nxt_s;
      if (wr_en)
        mem[{s_ff.page, s_ff.idx}] <= s_ff.pbuf[{s_ff.idx, 3'h0} +: 8];
    end
  end

  assign o_rd_data = mem[i_rd_addr];
  assign o_busy    = s_ff.busy;
  assign o_abort   = s_ff.abort;
endmodule  // eep_wcycle

// file: hdl/eep_dev_end.sv
/*
  Device end of the two-wire EEPROM link: start and stop detection,
  address match, acknowledge, page buffer, address counter, reads.
  Assumes SCL from the master as its clock and a master that keeps
  the usual setup and hold times; i_sys_rst resets all domains.
*/
`timescale 1ns/10ps
module eep_dev_end #(
  parameter int TWR_CYC = eep_pkg::TWR_CYC
) (
  eep_link_if.dev   link,
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  output logic      o_busy,
  output logic      o_abort
);
  import eep_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_RX = 2'b01, S_TX = 2'b11, S_WAIT = 2'b10
  } eep_dst_t;

  typedef struct packed {
    eep_dst_t          st;
    logic [3:0]        bitcnt;
    logic [1:0]        bidx;
    logic [7:0]        shreg;
    logic              rw;
    logic              ack_en;
    logic              first;
    logic              inc_pend;
    logic              cancel;
    logic              wr_ok;
    logic              start_seen;
    logic [1:0]        wps;
    logic [1:0]        bsys;
    logic [ADDR_W-1:0] addr;
    logic [PAGE_N-1:0] mask;
    eep_page_t         pbuf;
  } eep_dev_t;

  eep_dev_t         s_ff;
  eep_dev_t         nxt_s;
  logic             start_tgl_ff;
  logic             stop_tgl_ff;
  logic             start_cap_ff;
  logic             drive_ff;
  logic             nxt_drive;
  logic [7:0]       byte_in;
  logic [OFS_W-1:0] ofs;
  logic [7:0]       rd_data;
  logic             busy;

  function automatic logic addr_match(input logic [7:0] b);
    return b[7:1] == {TYPE_ID, SUB_ADDR};
  endfunction

  // Start and stop are seen on SDA edges while SCL is high
  always_ff @(negedge link.sda or posedge i_sys_rst) begin
    if (i_sys_rst) start_tgl_ff <= 1'b0;
    else if (link.scl) start_tgl_ff <= ~start_tgl_ff;
  end

  always_ff @(posedge link.sda or posedge i_sys_rst) begin
    if (i_sys_rst) stop_tgl_ff <= 1'b0;
    else if (link.scl) stop_tgl_ff <= ~stop_tgl_ff;
  end

  // Start toggle is steady by the first SCL fall after the start
  always_ff @(negedge link.scl or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_cap_ff <= 1'b0;
      drive_ff     <= 1'b0;
    end else begin
      start_cap_ff <= start_tgl_ff;
      drive_ff     <= nxt_drive;
    end
  end

  always_comb begin
    nxt_drive = 1'b0;
    if (s_ff.st == S_RX && s_ff.bitcnt == ACK_BIT && s_ff.ack_en)
      nxt_drive = 1'b1;
    else if (s_ff.st == S_TX && s_ff.bitcnt != ACK_BIT)
      nxt_drive = !rd_data[3'h7 - s_ff.bitcnt[2:0]];
  end

  always_comb begin
    nxt_s      = s_ff;
    byte_in    = {s_ff.shreg[6:0], link.sda};
    ofs        = s_ff.first ? s_ff.addr[OFS_W-1:0]
                            : s_ff.addr[OFS_W-1:0] + 5'h1;
    nxt_s.wps  = {s_ff.wps[0], link.wp};
    nxt_s.bsys = {s_ff.bsys[0], busy};
    if (start_cap_ff != s_ff.start_seen) begin
      nxt_s.start_seen = start_cap_ff;
      nxt_s.st         = S_RX;
      // The edge that sees the start also carries the first address bit
      nxt_s.shreg      = byte_in;
      nxt_s.bitcnt     = 4'h1;
      nxt_s.bidx       = BI_DEV;
      nxt_s.ack_en     = 1'b0;
      nxt_s.mask       = '0;
      nxt_s.cancel     = 1'b0;
    end else begin
      unique case (s_ff.st)
        S_IDLE, S_WAIT: begin
          nxt_s.ack_en = 1'b0;
        end
        S_RX: begin
          if (s_ff.bitcnt == ACK_BIT) begin
            nxt_s.bitcnt = '0;
            nxt_s.ack_en = 1'b0;
            if (s_ff.rw == RW_READ) begin
              nxt_s.st       = S_TX;
              nxt_s.inc_pend = 1'b1;
              if (s_ff.inc_pend)
                nxt_s.addr = s_ff.addr + 12'h1;
            end
          end else begin
            nxt_s.shreg  = byte_in;
            nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
            if (s_ff.bidx == BI_DATA && s_ff.wps[1])
              nxt_s.cancel = 1'b1;
            if (s_ff.bitcnt == LAST_BIT) begin
              nxt_s.ack_en = 1'b1;
              unique case (s_ff.bidx)
                BI_DEV: begin
                  nxt_s.rw   = byte_in[0];
                  nxt_s.bidx = BI_AHI;
                  if (!addr_match(byte_in) || s_ff.bsys[1]) begin
                    nxt_s.ack_en = 1'b0;
                    nxt_s.st     = S_WAIT;
                  end
                end
                BI_AHI: begin
                  nxt_s.addr[ADDR_W-1:8] = byte_in[3:0];
                  nxt_s.bidx             = BI_ALO;
                end
                BI_ALO: begin
                  nxt_s.addr[7:0] = byte_in;
                  nxt_s.inc_pend  = 1'b0;
                  nxt_s.first     = 1'b1;
                  nxt_s.mask      = '0;
                  nxt_s.bidx      = BI_DATA;
                end
                BI_DATA: begin
                  nxt_s.addr[OFS_W-1:0]     = ofs;
                  nxt_s.first               = 1'b0;
                  nxt_s.inc_pend            = 1'b0;
                  nxt_s.mask[ofs]           = 1'b1;
                  nxt_s.pbuf[{ofs, 3'h0} +: 8] = byte_in;
                end
              endcase
            end
          end
        end
        S_TX: begin
          if (s_ff.bitcnt == ACK_BIT) begin
            nxt_s.bitcnt = '0;
            if (!link.sda)
              nxt_s.addr = s_ff.addr + 12'h1;
            else
              nxt_s.st = S_WAIT;
          end else begin
            nxt_s.bitcnt = s_ff.bitcnt + 4'h1;
          end
        end
      endcase
    end
    nxt_s.wr_ok = (nxt_s.mask != '0) && !nxt_s.cancel;
  end

  always_ff @(posedge link.scl or posedge i_sys_rst) begin
    if (i_sys_rst) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  eep_wcycle #(
    .TWR_CYC (TWR_CYC)
  ) u_wcycle (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_stop_tgl (stop_tgl_ff),
    .i_wr_ok    (s_ff.wr_ok),
    .i_wp       (link.wp),
    .i_page     (s_ff.addr[ADDR_W-1:OFS_W]),
    .i_mask     (s_ff.mask),
    .i_pbuf     (s_ff.pbuf),
    .i_rd_addr  (s_ff.addr),
    .o_rd_data  (rd_data),
    .o_busy     (busy),
    .o_abort    (o_abort)
  );

  assign o_busy        = busy;
  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = drive_ff;
endmodule  // eep_dev_end

// file: verif/eep_link_properties.sv
/*
  Checker on the two-wire link between host and device ends.
  Assumes one system clock and reset shared by both ends.
*/
`timescale 1ns/10ps
module eep_link_properties #(
  parameter int TWR_CYC = 200
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  input wire logic wp,
  input wire logic o_busy
);
  typedef struct packed {
    logic        scl_q;
    logic        sda_q;
    logic        in_frame;
    logic        rw;
    logic        nacked;
    logic [3:0]  bit_n;
    logic [7:0]  byte_n;
    logic [3:0]  since_stop;
    logic [19:0] bcnt;
  } eep_chk_t;
  eep_chk_t st_ff;
  eep_chk_t nxt_st;
  logic     rise;
  logic     ack_bit;
  logic     start;
  logic     stop;
  assign rise    = scl & ~st_ff.scl_q;
  assign ack_bit = rise & (st_ff.bit_n == 4'h8);
  assign start   = scl & st_ff.scl_q & st_ff.sda_q & ~sda;
  assign stop    = scl & st_ff.scl_q & ~st_ff.sda_q & sda;
  // Bit and byte position within the frame, plus write-cycle length
  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_q = scl;
    nxt_st.sda_q = sda;
    nxt_st.bcnt = o_busy ? st_ff.bcnt + 20'h1 : 20'h0;
    if (st_ff.since_stop != 4'hF) begin
      nxt_st.since_stop = st_ff.since_stop + 4'h1;
    end
    if (rise) begin
      nxt_st.bit_n = (st_ff.bit_n == 4'h9) ? 4'h1 : st_ff.bit_n + 4'h1;
      if (st_ff.bit_n == 4'h9) begin
        nxt_st.byte_n = st_ff.byte_n + 8'h1;
      end
      if (st_ff.bit_n == 4'h7 && st_ff.byte_n == 8'h0) begin
        nxt_st.rw = sda;
      end
      if (ack_bit && st_ff.rw && st_ff.byte_n != 8'h0 && sda) begin
        nxt_st.nacked = 1'b1;
      end
    end
    if (start | stop) begin
      nxt_st.in_frame = start;
      nxt_st.bit_n = 4'h0;
      nxt_st.byte_n = 8'h0;
      nxt_st.nacked = 1'b0;
    end
    if (stop) begin
      nxt_st.since_stop = 4'h0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
      st_ff.scl_q <= 1'b1;
      st_ff.sda_q <= 1'b1;
      st_ff.since_stop <= 4'hF;
    end else begin
      st_ff <= nxt_st;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  frame_quiet_a: assert property (
    !st_ff.in_frame |-> !sda_s_oe) else $error("sda driven outside frame");
  fall_only_a: assert property (
    $changed(sda_s_oe) |-> !scl) else $error("sda moved with scl high");
  addr_ack_a: assert property (
    ack_bit && st_ff.byte_n == 8'h0 && !o_busy |-> sda_s_oe)
    else $error("address not acknowledged");
  write_ack_a: assert property (
    ack_bit && st_ff.byte_n != 8'h0 && !st_ff.rw |-> sda_s_oe)
    else $error("written byte not acknowledged");
  read_rel_a: assert property (
    ack_bit && st_ff.byte_n != 8'h0 && st_ff.rw |-> !sda_s_oe)
    else $error("sda held in master ack bit");
  data_rel_a: assert property (
    rise && st_ff.bit_n < 4'h8 && !(st_ff.rw && st_ff.byte_n != 8'h0)
    |-> !sda_s_oe) else $error("sda held while master sends");
  nack_quiet_a: assert property (
    st_ff.nacked |-> !sda_s_oe) else $error("data sent after nack");
  stop_start_a: assert property (
    $rose(o_busy) |-> st_ff.since_stop < 4'hC)
    else $error("write cycle without stop");
  wp_block_a: assert property (
    $rose(o_busy) |-> !wp) else $error("write cycle under protect");
  busy_len_a: assert property (
    o_busy |-> st_ff.bcnt < TWR_CYC) else $error("write cycle too long");
  busy_full_a: assert property (
    $fell(o_busy) && !wp |-> $past(st_ff.bcnt) >= TWR_CYC - 1)
    else $error("write cycle too short");
  abort_fast_a: assert property (
    o_busy && wp |-> ##[1:8] !o_busy) else $error("protect did not abort");
  cover property ($rose(o_busy));
  cover property (st_ff.nacked);
  cover property (o_busy && wp);
endmodule // eep_link_properties

// file: verif/tb.sv
/*
  Bench joining host and device ends over the two-wire link.
  Assumes a 50 MHz system clock and a shortened write cycle.
*/
`timescale 1ns/10ps
module tb;
  import eep_pkg::*;
  localparam int TWR = 200;
  localparam int LIM = 40000;
  logic              i_clk;
  logic              i_sys_rst;
  logic              cmd_valid;
  eep_op_t           cmd_op;
  logic [ADDR_W-1:0] cmd_addr;
  logic [LEN_W-1:0]  cmd_len;
  logic [7:0]        wdata;
  logic              wp_in;
  logic              cmd_ready;
  logic              wdata_take;
  logic [7:0]        rdata;
  logic              rdata_valid;
  logic              nack;
  logic              busy;
  logic              abort;
  logic [7:0]        wbuf [4];
  logic [7:0]        rq [$];
  int                widx;
  int                nacks;
  int                aborts;
  int                errors;
  int                total_checks;
  eep_link_if link ();
  eep_dev_end #(.TWR_CYC(TWR)) u_eep_dev_end (.link(link), .i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .o_busy(busy), .o_abort(abort));
  eep_host_end u_eep_host_end (.link(link), .i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
    .i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len), .i_wdata(wdata),
    .i_wp(wp_in), .o_cmd_ready(cmd_ready), .o_wdata_take(wdata_take),
    .o_rdata(rdata), .o_rdata_valid(rdata_valid), .o_nack(nack));
  eep_link_properties #(.TWR_CYC(TWR)) u_eep_link_properties (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .scl(link.scl), .sda(link.sda),
    .sda_s_oe(link.sda_s_oe), .wp(link.wp), .o_busy(busy));
  assign wdata = wbuf[widx];
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // Pulses are counted mid-cycle, where the host and device outputs have settled
  always @(negedge i_clk) begin
    if (rdata_valid === 1'b1) rq.push_back(rdata);
    if (wdata_take === 1'b1) widx <= widx + 1;
    if (nack === 1'b1) nacks++;
    if (abort === 1'b1) aborts++;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // Waits for command-ready (sel 0) or write-busy (sel 1) to reach lvl
  task automatic wait_lvl(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? cmd_ready : busy) !== lvl) begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > lim) begin
        errors++;
        stop_test();
      end
    end
  endtask
  task automatic run(input eep_op_t op, input logic [11:0] a,
                     input logic [12:0] len);
    wait_lvl(0, 1'b1, LIM);
    @(posedge i_clk);
    #1;
    cmd_op = op;
    cmd_addr = a;
    cmd_len = len;
    cmd_valid = 1'b1;
    @(posedge i_clk);
    #1;
    cmd_valid = 1'b0;
    wait_lvl(0, 1'b1, LIM);
  endtask
  initial begin
    i_sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_WRITE;
    cmd_addr = '0;
    cmd_len = '0;
    wp_in = 1'b0;
    widx = 0;
    nacks = 0;
    aborts = 0;
    errors = 0;
    total_checks = 0;
    wbuf = '{8'h11, 8'h22, 8'h33, 8'h00};
    repeat (3) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    repeat (5) @(posedge i_clk);
    // Page write across the page end: third byte wraps to offset 0
    run(OP_WRITE, 12'h03E, 13'h3);
    wait_lvl(1, 1'b1, 50);
    wait_lvl(1, 1'b0, 1000);
    check("bytes taken", 8'(widx), 8'h03);
    run(OP_CUR, 12'h000, 13'h2);
    check("current read", rq[0], 8'h33);
    check("next byte", rq[1], ERASED);
    run(OP_RAND, 12'h03D, 13'h2);
    check("random read", rq[2], ERASED);
    check("sequential", rq[3], 8'h11);
    run(OP_CUR, 12'h000, 13'h1);
    check("after read", rq[4], 8'h22);
    // Protect raised inside the write cycle cuts it short
    widx = 0;
    wbuf[0] = 8'h44;
    run(OP_WRITE, 12'h200, 13'h1);
    wait_lvl(1, 1'b1, 50);
    wp_in = 1'b1;
    wait_lvl(1, 1'b0, 20);
    repeat (2) @(posedge i_clk);
    #1;
    check("abort pulses", 8'(aborts), 8'h01);
    // Protect still high through a write: no write cycle may start
    run(OP_WRITE, 12'h100, 13'h1);
    check("cancel busy", {7'h0, busy}, 8'h00);
    check("nack count", 8'(nacks), 8'h00);
    stop_test();
  end
endmodule // tb
